// *** common/udz_pkg.sv ***
package udz_pkg;
  localparam int WORD_W = 32;
  localparam int IMM_W = 16;
  // Operation select encoding
  typedef enum logic [1:0] {
    UDZ_OP_DIVU = 2'h0,
    UDZ_OP_DOZ = 2'h1,
    UDZ_OP_DOZI = 2'h2,
    UDZ_OP_NONE = 2'h3
  } udz_op_t;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [WORD_W-1:0] WORD_ONE = 32'h00000001;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [5:0] STEP_ZERO = 6'h00;
  localparam logic [5:0] STEP_ONE = 6'h01;
endpackage : udz_pkg

// *** src/udz_divider.sv ***
`timescale 1ns/100ps
// Restoring unsigned divider, one quotient bit per clock
module udz_divider (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Request
  input wire logic start,
  input wire logic [udz_pkg::WORD_W-1:0] dividend,
  input wire logic [udz_pkg::WORD_W-1:0] divisor,
  // Answer
  output logic busy,
  output logic done,
  output logic [udz_pkg::WORD_W-1:0] quotient
);
  import udz_pkg::*;

  logic [WORD_W-1:0] rem;
  logic [WORD_W-1:0] quo;
  logic [WORD_W-1:0] dsr;
  logic [5:0] step;
  logic [WORD_W-1:0] next_rem;
  logic [WORD_W-1:0] next_quo;
  logic [WORD_W-1:0] next_dsr;
  logic [5:0] next_step;
  logic next_busy;
  logic next_done;

  // One shift-subtract step per cycle; divisor zero yields all ones, which is allowed
  always_comb begin
    logic [WORD_W:0] trial;
    trial = {rem, quo[WORD_W-1]};
    next_rem = rem;
    next_quo = quo;
    next_dsr = dsr;
    next_step = step;
    next_busy = busy;
    next_done = 1'b0;
    if (start && !busy) begin
      next_rem = WORD_ZERO;
      next_quo = dividend;
      next_dsr = divisor;
      next_step = DIV_STEPS;
      next_busy = 1'b1;
    end else if (busy) begin
      if (trial >= {1'b0, dsr}) begin
        next_rem = trial[WORD_W-1:0] - dsr;
        next_quo = {quo[WORD_W-2:0], 1'b1};
      end else begin
        next_rem = trial[WORD_W-1:0];
        next_quo = {quo[WORD_W-2:0], 1'b0};
      end
      next_step = step - STEP_ONE;
      if (step == STEP_ONE) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rem <= WORD_ZERO;
      quo <= WORD_ZERO;
      dsr <= WORD_ZERO;
      step <= STEP_ZERO;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem <= next_rem;
      quo <= next_quo;
      dsr <= next_dsr;
      step <= next_step;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign quotient = quo;
endmodule : udz_divider

// *** src/udz_alu.sv ***
`timescale 1ns/100ps
// Behaviour
// - The unsigned divide writes first source divided by second source, all unsigned.
// - A zero divisor leaves the target value unspecified, so any value may be written.
// - With the record bit on the divide, the field 0 compare flags treat the quotient as signed.
// - Overflow-enable on divide or difference updates summary-overflow and overflow, else not.
// - Record bit on divide or difference updates field 0 flags, else field 0 is kept.
// - The carry flag is never modified by the divide or difference forms.
// - The register difference writes not first plus one plus second, i.e. second minus first.
// - If first exceeds second as signed numbers, the register difference writes zero.
// - The difference sets overflow only on a positive signed overflow.
// - The immediate difference writes not first plus sign-extended immediate plus one.
// - If first exceeds the signed immediate, the immediate difference writes zero.
// - The immediate difference leaves field 0 and the exception register unchanged.
module udz_alu (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Issue side
  input wire logic issue_valid,
  input wire udz_pkg::udz_op_t issue_op,
  input wire logic [udz_pkg::WORD_W-1:0] first_source_reg,
  input wire logic [udz_pkg::WORD_W-1:0] second_source_reg,
  input wire logic [udz_pkg::IMM_W-1:0] immediate,
  input wire logic overflow_enable,
  input wire logic record_bit,
  output logic issue_ready,
  // Software control of the exception register
  input wire logic summary_overflow_clear,
  input wire logic overflow_clear,
  input wire logic carry_flag_write,
  input wire logic carry_flag_value,
  // Writeback side
  output logic result_valid,
  output logic [udz_pkg::WORD_W-1:0] target_reg,
  output logic cr0_write,
  // Flag state
  output logic less_than_flag,
  output logic greater_than_flag,
  output logic equal_flag,
  output logic cr0_summary_overflow,
  output logic summary_overflow_flag,
  output logic overflow_flag,
  output logic carry_flag
);
  import udz_pkg::*;

  // Signed greater-than, used by both difference forms
  function automatic logic signed_gt(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    signed_gt = $signed(a) > $signed(b);
  endfunction : signed_gt

  // Complement-plus-one-plus-b sum, giving b minus a
  function automatic logic [WORD_W-1:0] diff_sum(input logic [WORD_W-1:0] a,
                                               input logic [WORD_W-1:0] b);
    diff_sum = ~a + b + WORD_ONE;
  endfunction : diff_sum

  // Sign of a word, for the field 0 compare
  function automatic logic is_negative(input logic [WORD_W-1:0] a);
    is_negative = a[WORD_W-1];
  endfunction : is_negative

  // All-zero test, shared by the equal and greater-than terms of field 0
  function automatic logic is_zero(input logic [WORD_W-1:0] a);
    is_zero = (a == WORD_ZERO);
  endfunction : is_zero

  // Divider handshake
  logic div_busy;
  logic div_done;
  logic [WORD_W-1:0] div_quotient;
  logic div_start;
  logic take;

  // Controls of a divide in flight
  logic pend_oe;
  logic pend_rc;
  logic next_pend_oe;
  logic next_pend_rc;

  // Operand paths of the two difference forms
  logic [WORD_W-1:0] sext_imm;
  logic [WORD_W-1:0] doz_sum;
  logic doz_zero;
  logic doz_pos_ovf;
  logic [WORD_W-1:0] dozi_sum;
  logic dozi_zero;

  // What finishes this cycle and which flag groups it may update
  logic finish_valid;
  logic [WORD_W-1:0] finish_value;
  logic xer_update;
  logic ov_value;
  logic cr0_update;

  // Next values of the result, the exception register and field 0
  logic [WORD_W-1:0] next_target;
  logic next_result_valid;
  logic next_so;
  logic next_ov;
  logic next_ca;
  logic next_cr0_write;
  logic next_lt;
  logic next_gt;
  logic next_eq;
  logic next_cr0_so;

  // Divider takes many cycles; issue stalls while it runs
  udz_divider u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(div_start),
    .dividend(first_source_reg),
    .divisor(second_source_reg),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quotient)
  );

  // Issue stalls from a divide take until the cycle after its quotient, so a divide
  // result and a new difference never finish together
  assign take = issue_valid && issue_ready;
  assign issue_ready = !div_busy && !div_done;
  assign div_start = take && (issue_op == UDZ_OP_DIVU);

  // Register difference: second minus first, clamped when first is the larger
  assign doz_sum = diff_sum(first_source_reg, second_source_reg);
  assign doz_zero = signed_gt(first_source_reg, second_source_reg);
  // Only b positive, a negative, sum negative is a positive overflow; a negative
  // overflow needs the larger first source, which the clamp hides anyway
  assign doz_pos_ovf = !second_source_reg[WORD_W-1] && first_source_reg[WORD_W-1]
                       && doz_sum[WORD_W-1];

  // Immediate difference uses the same sum and clamp on the sign-extended immediate
  assign sext_imm = {{(WORD_W-IMM_W){immediate[IMM_W-1]}}, immediate};
  assign dozi_sum = diff_sum(first_source_reg, sext_imm);
  assign dozi_zero = signed_gt(first_source_reg, sext_imm);

  // What finishes this cycle, and which flag groups it may touch
  always_comb begin
    finish_valid = 1'b0;
    finish_value = WORD_ZERO;
    xer_update = 1'b0;
    ov_value = 1'b0;
    cr0_update = 1'b0;
    if (div_done) begin
      // A zero divisor leaves an all-ones quotient and reports no overflow
      finish_valid = 1'b1;
      finish_value = div_quotient;
      xer_update = pend_oe;
      ov_value = 1'b0;
      cr0_update = pend_rc;
    end else if (take) begin
      case (issue_op)
        UDZ_OP_DOZ: begin
          finish_valid = 1'b1;
          finish_value = doz_zero ? WORD_ZERO : doz_sum;
          xer_update = overflow_enable;
          ov_value = !doz_zero && doz_pos_ovf;
          cr0_update = record_bit;
        end
        UDZ_OP_DOZI: begin
          // No flag group is touched by the immediate form
          finish_valid = 1'b1;
          finish_value = dozi_zero ? WORD_ZERO : dozi_sum;
        end
        default: begin
          // A divide finishes later; an empty slot finishes nothing
          finish_valid = 1'b0;
        end
      endcase
    end
  end

  // Overflow-enable and record bit of a divide wait here for its quotient, as the
  // issue ports are free to change while the divider runs
  always_comb begin
    next_pend_oe = pend_oe;
    next_pend_rc = pend_rc;
    if (div_start) begin
      next_pend_oe = overflow_enable;
      next_pend_rc = record_bit;
    end
  end

  // Pending divide controls
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pend_oe <= 1'b0;
      pend_rc <= 1'b0;
    end else begin
      pend_oe <= next_pend_oe;
      pend_rc <= next_pend_rc;
    end
  end

  // Target holds between results, so writeback may read it after the strobe
  always_comb begin
    next_result_valid = finish_valid;
    next_target = target_reg;
    if (finish_valid) begin
      next_target = finish_value;
    end
  end

  // Result registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      target_reg <= WORD_ZERO;
      result_valid <= 1'b0;
    end else begin
      target_reg <= next_target;
      result_valid <= next_result_valid;
    end
  end

  // Overflow pair; a set by the instruction wins over a software clear in the same
  // cycle, so an overflow is never lost to a clear that races it
  always_comb begin
    next_so = summary_overflow_flag && !summary_overflow_clear;
    next_ov = overflow_flag && !overflow_clear;
    if (xer_update) begin
      next_ov = ov_value;
      if (ov_value) begin
        next_so = 1'b1;
      end
    end
  end

  // Overflow pair registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      summary_overflow_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      summary_overflow_flag <= next_so;
      overflow_flag <= next_ov;
    end
  end

  // Carry belongs to software alone; no instruction path reaches it, which keeps
  // the divide and difference forms from disturbing a carry chain in flight
  always_comb begin
    next_ca = carry_flag;
    if (carry_flag_write) begin
      next_ca = carry_flag_value;
    end
  end

  // Carry register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      carry_flag <= 1'b0;
    end else begin
      carry_flag <= next_ca;
    end
  end

  // Field 0 strobe pulses with the result it belongs to
  always_comb begin
    next_cr0_write = cr0_update;
  end

  // Field 0 strobe register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cr0_write <= 1'b0;
    end else begin
      cr0_write <= next_cr0_write;
    end
  end

  // Field 0 flags compare the result with zero as a signed word, also after a divide
  always_comb begin
    next_lt = less_than_flag;
    next_gt = greater_than_flag;
    next_eq = equal_flag;
    next_cr0_so = cr0_summary_overflow;
    if (cr0_update) begin
      next_lt = is_negative(finish_value);
      next_gt = !is_negative(finish_value) && !is_zero(finish_value);
      next_eq = is_zero(finish_value);
      // Field 0 copies the summary overflow as it stands after this instruction
      next_cr0_so = next_so;
    end
  end

  // Field 0 registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      less_than_flag <= 1'b0;
      greater_than_flag <= 1'b0;
      equal_flag <= 1'b0;
      cr0_summary_overflow <= 1'b0;
    end else begin
      less_than_flag <= next_lt;
      greater_than_flag <= next_gt;
      equal_flag <= next_eq;
      cr0_summary_overflow <= next_cr0_so;
    end
  end
endmodule : udz_alu

// *** testbench/udz_alu_checker.sv ***
`timescale 1ns/100ps
// Timing and flag relations seen at the ALU ports
module udz_alu_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Issue side
  input wire logic issue_valid,
  input wire udz_pkg::udz_op_t issue_op,
  input wire logic [udz_pkg::WORD_W-1:0] first_source_reg,
  input wire logic [udz_pkg::WORD_W-1:0] second_source_reg,
  input wire logic overflow_enable,
  input wire logic record_bit,
  input wire logic issue_ready,
  input wire logic overflow_clear,
  input wire logic carry_flag_write,
  // Results and flags
  input wire logic result_valid,
  input wire logic [udz_pkg::WORD_W-1:0] target_reg,
  input wire logic cr0_write,
  input wire logic equal_flag,
  input wire logic summary_overflow_flag,
  input wire logic overflow_flag,
  input wire logic carry_flag
);
  import udz_pkg::*;
  wire take = issue_valid && issue_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // A divide is one take edge followed by a refused stretch
  sequence s_div_take;
    take && issue_op == UDZ_OP_DIVU;
  endsequence
  sequence s_div_busy;
    !issue_ready [*8];
  endsequence
  a_div_answer: assert property (s_div_take |-> ##34 result_valid)
    else $error("divide answer not on cycle 34");
  a_div_refuse: assert property (s_div_take |=> s_div_busy)
    else $error("request accepted while dividing");
  a_doz_clamp: assert property (take && issue_op == UDZ_OP_DOZ &&
    $signed(first_source_reg) > $signed(second_source_reg) |=> target_reg == WORD_ZERO)
    else $error("difference not clamped to zero");
  a_rc_update: assert property (take && issue_op == UDZ_OP_DOZ |=>
    result_valid && cr0_write == $past(record_bit)) else $error("field 0 update wrong");
  a_dozi_keep: assert property (take && issue_op == UDZ_OP_DOZI && !overflow_clear |=>
    !cr0_write && $stable(overflow_flag)) else $error("immediate form touched flags");
  a_no_oe_keep: assert property (take && issue_op == UDZ_OP_DOZ && !overflow_enable &&
    !overflow_clear |=> $stable(overflow_flag)) else $error("overflow changed without enable");
  a_carry_kept: assert property (!carry_flag_write |=> $stable(carry_flag))
    else $error("carry changed by the ALU");
  a_ov_sets_so: assert property ($rose(overflow_flag) |-> summary_overflow_flag)
    else $error("overflow without summary overflow");
  a_zero_equal: assert property (cr0_write && target_reg == WORD_ZERO |-> equal_flag)
    else $error("zero result without equal flag");
endmodule : udz_alu_checker

bind udz_alu udz_alu_checker u_chk (.clk_sys, .rst_b, .issue_valid, .issue_op,
  .first_source_reg, .second_source_reg, .overflow_enable, .record_bit, .issue_ready,
  .overflow_clear, .carry_flag_write, .result_valid, .target_reg, .cr0_write,
  .equal_flag, .summary_overflow_flag, .overflow_flag, .carry_flag);

// *** testbench/udz_issue_model.sv ***
`timescale 1ns/100ps
// Issue logic: holds one request until the ALU takes it
module udz_issue_model (
  // Clock and handshake
  input wire logic clk_sys,
  input wire logic issue_ready,
  // Request fields
  output logic issue_valid,
  output udz_pkg::udz_op_t issue_op,
  output logic [udz_pkg::WORD_W-1:0] first_source_reg,
  output logic [udz_pkg::WORD_W-1:0] second_source_reg,
  output logic [udz_pkg::IMM_W-1:0] immediate,
  output logic overflow_enable,
  output logic record_bit
);
  import udz_pkg::*;
  // Idle values at time zero
  initial begin
    issue_valid = 1'b0;
    issue_op = UDZ_OP_NONE;
    {first_source_reg, second_source_reg, immediate} = '0;
    {overflow_enable, record_bit} = 2'h0;
  end
  // Operands are inverted once released, so a late sample reads garbage
  task automatic send(input udz_op_t op, input logic [WORD_W-1:0] a, b, input logic oe, rc);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_op <= op;
    first_source_reg <= a;
    second_source_reg <= b;
    immediate <= b[IMM_W-1:0];
    overflow_enable <= oe;
    record_bit <= rc;
    do @(negedge clk_sys); while (issue_ready !== 1'b1);
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    first_source_reg <= ~a;
    second_source_reg <= ~b;
    immediate <= ~b[IMM_W-1:0];
  endtask : send
endmodule : udz_issue_model

// *** testbench/tb_udz_alu.sv ***
`timescale 1ns/100ps
// Self-checking bench for the divide and difference-or-zero ALU
module tb_udz_alu;
  import udz_pkg::*;
  logic clk_sys, rst_b, summary_overflow_clear, overflow_clear, carry_flag_write;
  logic carry_flag_value, issue_valid, issue_ready, overflow_enable, record_bit;
  udz_op_t issue_op;
  logic [WORD_W-1:0] first_source_reg, second_source_reg, target_reg;
  logic [IMM_W-1:0] immediate;
  logic result_valid, cr0_write, lt, gt, eq, cr0_so, so, ov, ca;
  int n_errors = 0, checks = 0, cycles = 0;
  udz_issue_model u_iss (.clk_sys, .issue_ready, .issue_valid, .issue_op, .first_source_reg,
    .second_source_reg, .immediate, .overflow_enable, .record_bit);
  udz_alu u_dut (.clk_sys, .rst_b, .issue_valid, .issue_op, .first_source_reg,
    .second_source_reg, .immediate, .overflow_enable, .record_bit, .issue_ready,
    .summary_overflow_clear, .overflow_clear, .carry_flag_write, .carry_flag_value,
    .result_valid, .target_reg, .cr0_write, .less_than_flag(lt), .greater_than_flag(gt),
    .equal_flag(eq), .cr0_summary_overflow(cr0_so), .summary_overflow_flag(so),
    .overflow_flag(ov), .carry_flag(ca));
  // Clock, and a ceiling well above the ~130 cycles the run needs
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp_w(input logic [WORD_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_w
  task automatic cmp_b(input logic got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_b
  // One request, then a bounded wait for its result
  task automatic run(input udz_op_t op, input logic [WORD_W-1:0] a, b, input logic oe, rc);
    int n = 0;
    u_iss.send(op, a, b, oe, rc);
    do begin
      @(negedge clk_sys);
      n++;
    end while (result_valid !== 1'b1 && n < 40);
    cmp_b(result_valid, 1'b1);
  endtask : run
  // One-cycle pulse on a software flag control: 0 overflow, 1 summary, else carry write
  task automatic pulse(input int which);
    @(posedge clk_sys);
    case (which)
      0: overflow_clear <= 1'b1;
      1: summary_overflow_clear <= 1'b1;
      default: carry_flag_write <= 1'b1;
    endcase
    @(posedge clk_sys);
    {summary_overflow_clear, overflow_clear, carry_flag_write} <= 3'h0;
    @(negedge clk_sys);
  endtask : pulse
  task automatic t_divide();
    run(UDZ_OP_DIVU, 32'h80000000, 32'h00000002, 1'b0, 1'b1);
    cmp_w(target_reg, 32'h40000000);
    cmp_b(gt, 1'b1);
    run(UDZ_OP_DIVU, 32'hFFFFFFFF, 32'h00000001, 1'b1, 1'b1);
    cmp_w(target_reg, 32'hFFFFFFFF);
    cmp_b(lt, 1'b1);
    cmp_b(ov, 1'b0);
    run(UDZ_OP_DIVU, 32'h00000001, 32'h00000000, 1'b1, 1'b0);
    cmp_b(ca, 1'b0);
  endtask : t_divide
  task automatic t_doz();
    run(UDZ_OP_DOZ, 32'h00000001, 32'h00000002, 1'b0, 1'b0);
    cmp_w(target_reg, 32'h00000001);
    run(UDZ_OP_DOZ, 32'h00000001, 32'hFFFFFFFF, 1'b0, 1'b1);
    cmp_w(target_reg, 32'h00000000);
    cmp_b(eq, 1'b1);
    run(UDZ_OP_DOZ, 32'hEFFFFFFF, 32'h00000000, 1'b0, 1'b1);
    cmp_w(target_reg, 32'h10000001);
    run(UDZ_OP_DOZ, 32'h80000000, 32'h7FFFFFFF, 1'b1, 1'b1);
    cmp_b(ov, 1'b1);
    cmp_b(cr0_so, 1'b1);
  endtask : t_doz
  task automatic t_dozi();
    run(UDZ_OP_DOZI, 32'h00000001, 32'h00000000, 1'b1, 1'b1);
    cmp_w(target_reg, 32'h00000000);
    run(UDZ_OP_DOZI, 32'h00000005, 32'h00008000, 1'b1, 1'b1);
    cmp_w(target_reg, 32'h00000000);
    run(UDZ_OP_DOZI, 32'hFFFF8000, 32'h00007FFF, 1'b0, 1'b0);
    cmp_w(target_reg, 32'h0000FFFF);
    cmp_b(ov, 1'b1);
  endtask : t_dozi
  // Overflow may clear while summary overflow stays until its own clear
  task automatic t_sticky();
    pulse(0);
    cmp_b(so, 1'b1);
    run(UDZ_OP_DOZ, 32'h00000002, 32'h00000008, 1'b1, 1'b0);
    cmp_w(target_reg, 32'h00000006);
    cmp_b(so, 1'b1);
    pulse(1);
    cmp_b(so, 1'b0);
    @(posedge clk_sys);
    carry_flag_value <= 1'b1;
    pulse(2);
    run(UDZ_OP_DOZ, 32'h80000000, 32'h7FFFFFFF, 1'b1, 1'b1);
    cmp_b(ca, 1'b1);
  endtask : t_sticky
  // Reset for two cycles, then the scenarios
  initial begin
    rst_b = 1'b0;
    {summary_overflow_clear, overflow_clear, carry_flag_write, carry_flag_value} = 4'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_divide();
    t_doz();
    t_dozi();
    t_sticky();
    report_and_stop();
  end
endmodule : tb_udz_alu
